// ---- rtl/atc_core.sv ----
/*
 * Timer/counter core: prescaler, clock select, up/down counter, compare,
 * overflow and compare flags with masks.
 * Assumes CPU strobes are synchronous to CLK, but not the oscillator input;
 * the oscillator input is taken as a level and edge-detected after a
 * two-flop synchroniser.
 */
`timescale 1ns/1ps

// Functional notes
// - counter and compare value are eight bits each
// - each interrupt request is a flag, gated by its own mask bit
// - clock select zero stops the counter, no ticks produced
// - ticks come from io clock, or oscillator pin when async select set
// - compare checked on every tick; match sets flag and feeds waveform output
// - zero is bottom, 0xFF is max
// - top is 0xFF or the compare value, per mode
// - each tick clears, increments or decrements the counter
// - CPU may read and write the counter anytime, even stopped
// - CPU counter write beats clear or count
// - two waveform mode bits choose the counting sequence
// - overflow flag set per mode and can raise an interrupt
// - top and bottom indications when counter hits max and zero
// - ten-bit prescaler supplies synchronous tick choices
// - compare flag set in tick after the match
// - normal mode counts up, wraps, overflow flag set on becoming zero
// - mode 2 clears counter on compare match, compare is top
// - CPU counter write blocks compare match in next tick, even stopped
module atc_core
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic [2:0] CLOCK_SOURCE_SEL,
    input  wire logic [1:0] WAVEFORM_MODE_SEL,
    input  wire logic       ASYNC_CLOCK_SEL,
    input  wire logic       OSC_IN_PIN,
    input  wire logic       COUNT_WR,
    input  wire logic [7:0] COUNT_WDATA,
    input  wire logic       COMPARE_WR,
    input  wire logic [7:0] COMPARE_WDATA,
    input  wire logic [1:0] FLAG_CLR,
    input  wire logic [1:0] TIMER_MASK_REG,
    output logic      [7:0] TIMER_COUNT,
    output logic      [7:0] COMPARE_VALUE,
    output logic      [1:0] TIMER_FLAG_REG,
    output logic            OVF_IRQ,
    output logic            CMP_IRQ,
    output logic            COMPARE_OUTPUT,
    output logic            TOP_HIT,
    output logic            BOTTOM_HIT
);

    // ****************************************************************
    // prescaler and clock select
    // ****************************************************************
    logic [9:0] prescale;
    logic       osc_meta;
    logic       osc_sync;
    logic       osc_prev;
    logic       dir_down;
    logic       block_cmp;

    wire logic [9:0] next_prescale = prescale + 10'h001;
    wire logic       osc_tick      = osc_sync & ~osc_prev;

    function automatic logic pre_tap(input logic [2:0] sel, input logic [9:0] p);
        case (sel)
            3'b001:  pre_tap = 1'b1;
            3'b010:  pre_tap = &p[2:0];
            3'b011:  pre_tap = &p[4:0];
            3'b100:  pre_tap = &p[5:0];
            3'b101:  pre_tap = &p[6:0];
            3'b110:  pre_tap = &p[7:0];
            3'b111:  pre_tap = &p[9:0];
            default: pre_tap = 1'b0;
        endcase
    endfunction : pre_tap

    wire logic stopped  = (CLOCK_SOURCE_SEL == atc_pkg::CS_STOP);
    wire logic src_tick = ASYNC_CLOCK_SEL ? osc_tick
                                          : pre_tap(CLOCK_SOURCE_SEL, prescale);
    wire logic tick     = ~stopped & src_tick;

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            prescale <= atc_pkg::PRE_RESET;
        else
            prescale <= next_prescale;
    end

    // two-flop synchroniser for the oscillator level
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            osc_meta <= 1'b0;
            osc_sync <= 1'b0;
            osc_prev <= 1'b0;
        end
        else
        begin
            osc_meta <= OSC_IN_PIN;
            osc_sync <= osc_meta;
            osc_prev <= osc_sync;
        end
    end

    // ****************************************************************
    // counter unit
    // ****************************************************************
    wire logic is_bottom = (TIMER_COUNT == atc_pkg::BOTTOM_VAL);
    wire logic is_max    = (TIMER_COUNT == atc_pkg::MAX_VAL);
    wire logic is_pwm    = (WAVEFORM_MODE_SEL == atc_pkg::WM_PCPWM);
    wire logic ctc_mode  = (WAVEFORM_MODE_SEL == atc_pkg::WM_CTC);
    wire logic [7:0] top_val = ctc_mode ? COMPARE_VALUE : atc_pkg::MAX_VAL;
    wire logic at_top    = (TIMER_COUNT == top_val);
    wire logic match     = (TIMER_COUNT == COMPARE_VALUE);

    // phase correct turns around at top and bottom
    wire logic next_dir_down = (WAVEFORM_MODE_SEL == atc_pkg::WM_PCPWM)
                               ? (at_top ? 1'b1 : (is_bottom ? 1'b0 : dir_down))
                               : 1'b0;

    logic [7:0] next_count;
    always_comb
    begin
        if (ctc_mode && match)
            next_count = atc_pkg::BOTTOM_VAL;
        else if (next_dir_down)
            next_count = TIMER_COUNT - 8'h01;
        else
            next_count = TIMER_COUNT + 8'h01;
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            TIMER_COUNT <= atc_pkg::CNT_RESET;
            dir_down    <= 1'b0;
        end
        else if (COUNT_WR)
            TIMER_COUNT <= COUNT_WDATA;
        else if (tick)
        begin
            TIMER_COUNT <= next_count;
            dir_down    <= next_dir_down;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            COMPARE_VALUE <= atc_pkg::CMP_RESET;
        else if (COMPARE_WR)
            COMPARE_VALUE <= COMPARE_WDATA;
    end

    // ****************************************************************
    // compare blocking and flags
    // ****************************************************************
    // a counter write arms the block; it is spent on the next tick
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            block_cmp <= 1'b0;
        else if (COUNT_WR)
            block_cmp <= 1'b1;
        else if (tick)
            block_cmp <= 1'b0;
    end

    wire logic good_match = match & ~block_cmp & ~COUNT_WR;
    // up-counting modes overflow on the wrap from max; a compare clear sets it only when the compare value is max
    wire logic ovf_event  = tick & ~COUNT_WR &
                            (is_pwm ? (next_dir_down ? 1'b0 : is_bottom)
                                    : is_max);
    // the match seen at this tick sets the flag for the following timer cycle
    wire logic cmp_event  = tick & good_match;

    wire logic [1:0] set_flags = {cmp_event, ovf_event};
    wire logic [1:0] next_flags = (TIMER_FLAG_REG & ~FLAG_CLR) | set_flags; // set beats clear

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            TIMER_FLAG_REG <= 2'b00;
            COMPARE_OUTPUT <= 1'b0;
            TOP_HIT        <= 1'b0;
            BOTTOM_HIT     <= 1'b0;
        end
        else
        begin
            TIMER_FLAG_REG <= next_flags;
            if (tick && good_match)
                COMPARE_OUTPUT <= ~COMPARE_OUTPUT;
            TOP_HIT        <= is_max;
            BOTTOM_HIT     <= is_bottom;
        end
    end

    assign OVF_IRQ = TIMER_FLAG_REG[atc_pkg::OVF_BIT] & TIMER_MASK_REG[atc_pkg::OVF_BIT];
    assign CMP_IRQ = TIMER_FLAG_REG[atc_pkg::CMP_BIT] & TIMER_MASK_REG[atc_pkg::CMP_BIT];

    // ****************************************************************
    // checks
    // ****************************************************************
    property p_stop;
        @(posedge CLK) disable iff (RST)
        (stopped && !COUNT_WR) |=> (TIMER_COUNT == $past(TIMER_COUNT));
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while stopped");

    property p_wr_wins;
        @(posedge CLK) disable iff (RST)
        COUNT_WR |=> (TIMER_COUNT == $past(COUNT_WDATA));
    endproperty
    a_wr_wins: assert property (p_wr_wins) else $error("cpu write lost");

    property p_ctc_clear;
        @(posedge CLK) disable iff (RST)
        (tick && ctc_mode && match && !COUNT_WR) |=> (TIMER_COUNT == 8'h00);
    endproperty
    a_ctc_clear: assert property (p_ctc_clear) else $error("ctc did not clear");

    property p_norm_ovf;
        @(posedge CLK) disable iff (RST)
        (tick && WAVEFORM_MODE_SEL == 2'b00 && is_max && !COUNT_WR)
            |=> (TIMER_COUNT == 8'h00) && TIMER_FLAG_REG[0];
    endproperty
    a_norm_ovf: assert property (p_norm_ovf) else $error("normal wrap missed overflow");

    property p_norm_up;
        @(posedge CLK) disable iff (RST)
        (tick && WAVEFORM_MODE_SEL == 2'b00 && !COUNT_WR)
            |=> (TIMER_COUNT == $past(TIMER_COUNT) + 8'h01);
    endproperty
    a_norm_up: assert property (p_norm_up) else $error("normal mode not counting up");

    property p_block;
        @(posedge CLK) disable iff (RST)
        (tick && block_cmp)
            |=> (TIMER_FLAG_REG[1] == ($past(TIMER_FLAG_REG[1]) & ~$past(FLAG_CLR[1])));
    endproperty
    a_block: assert property (p_block) else $error("match not blocked after write");

    property p_cmp_flag;
        @(posedge CLK) disable iff (RST)
        (tick && match && !block_cmp && !COUNT_WR) |=> TIMER_FLAG_REG[1];
    endproperty
    a_cmp_flag: assert property (p_cmp_flag) else $error("compare flag late");

    property p_irq;
        @(posedge CLK) disable iff (RST)
        OVF_IRQ |-> (TIMER_FLAG_REG[0] && TIMER_MASK_REG[0]);
    endproperty
    a_irq: assert property (p_irq) else $error("overflow irq without flag and mask");

    property p_bottom;
        @(posedge CLK) disable iff (RST)
        (TIMER_COUNT == 8'h00) |=> BOTTOM_HIT;
    endproperty
    a_bottom: assert property (p_bottom) else $error("bottom not flagged");

endmodule : atc_core

// ---- inc/atc_pkg.sv ----
/*
 * Constants and types for the 8-bit timer/counter core.
 * Assumes a single 200 MHz system clock; no bus, loose control bits.
 */
package atc_pkg;

    // ****************************************************************
    // widths and extreme values
    // ****************************************************************
    localparam int        CNT_W      = 8;
    localparam int        PRE_W      = 10;
    localparam logic [7:0] BOTTOM_VAL = 8'h00;
    localparam logic [7:0] MAX_VAL    = 8'hFF;
    localparam logic [7:0] CNT_RESET  = 8'h00;
    localparam logic [7:0] CMP_RESET  = 8'h00;
    localparam logic [9:0] PRE_RESET  = 10'h000;

    // ****************************************************************
    // clock source select codes
    // ****************************************************************
    typedef enum logic [2:0] {
        CS_STOP   = 3'b000,
        CS_DIV1   = 3'b001,
        CS_DIV8   = 3'b010,
        CS_DIV32  = 3'b011,
        CS_DIV64  = 3'b100,
        CS_DIV128 = 3'b101,
        CS_DIV256 = 3'b110,
        CS_DIV1K  = 3'b111
    } atc_cs_t;

    // ****************************************************************
    // waveform mode codes
    // ****************************************************************
    typedef enum logic [1:0] {
        WM_NORMAL = 2'b00,
        WM_PCPWM  = 2'b01,
        WM_CTC    = 2'b10,
        WM_FAST   = 2'b11
    } atc_wm_t;

    // flag and mask bit positions
    localparam int OVF_BIT = 0;
    localparam int CMP_BIT = 1;

endpackage : atc_pkg

// ---- tb/atc_core_tb.sv ----
/*
 * Self-checking bench for atc_core: a table of clock-select rows, then
 * hand-written mode, compare, write and reset cases.
 * Assumes a 200 MHz clock and inputs driven on the rising edge.
 */
`timescale 1ns/1ps
module atc_core_tb;
    logic       clk, rst, async_sel, osc, cnt_wr, cmp_wr, cmp_out, top_hit, bot_hit;
    logic       ovf_irq, cmp_irq, co0;
    logic [2:0] cs;
    logic [1:0] wm, flag_clr, mask, flags;
    logic [7:0] cnt_wd, cmp_wd, count, cmp_val;
    int         n_errors, compares, cycles, i;
    // ****************************************************************
    // rows: select code, cycles run, ticks expected, tolerance
    // ****************************************************************
    logic [2:0] row_cs [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    int         row_n  [8] = '{64, 4, 32, 128, 256, 512, 1024, 4096};
    int         row_t  [8] = '{0, 4, 4, 4, 4, 4, 4, 4};
    int         row_e  [8] = '{0, 1, 1, 1, 1, 1, 1, 1};
    atc_core u_atc_core (.CLK(clk), .RST(rst), .CLOCK_SOURCE_SEL(cs),
        .WAVEFORM_MODE_SEL(wm), .ASYNC_CLOCK_SEL(async_sel), .OSC_IN_PIN(osc),
        .COUNT_WR(cnt_wr), .COUNT_WDATA(cnt_wd), .COMPARE_WR(cmp_wr),
        .COMPARE_WDATA(cmp_wd), .FLAG_CLR(flag_clr), .TIMER_MASK_REG(mask),
        .TIMER_COUNT(count), .COMPARE_VALUE(cmp_val), .TIMER_FLAG_REG(flags),
        .OVF_IRQ(ovf_irq), .CMP_IRQ(cmp_irq), .COMPARE_OUTPUT(cmp_out),
        .TOP_HIT(top_hit), .BOTTOM_HIT(bot_hit));
    initial
    begin
        clk = 1'h0;
        forever #2.5 clk = ~clk;
    end
    task automatic tally_and_finish;
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        if (got !== exp)
            n_errors++;
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    task automatic wr_cnt(input logic [7:0] v);
        @(posedge clk);
        cnt_wr <= 1'h1;
        cnt_wd <= v;
        @(posedge clk);
        cnt_wr <= 1'h0;
        #1;
    endtask : wr_cnt
    task automatic wr_cmp(input logic [7:0] v);
        @(posedge clk);
        cmp_wr <= 1'h1;
        cmp_wd <= v;
        @(posedge clk);
        cmp_wr <= 1'h0;
        #1;
    endtask : wr_cmp
    task automatic clr(input logic [1:0] v);
        @(posedge clk);
        flag_clr <= v;
        @(posedge clk);
        flag_clr <= 2'h0;
        #1;
    endtask : clr
    task automatic set_cs(input logic [2:0] v);
        @(posedge clk);
        cs <= v;
        #1;
    endtask : set_cs
    task automatic wait_val(input logic [7:0] v);
        int k;
        k = 0;
        while (count !== v && k < 600)
        begin
            cyc(1);
            k++;
        end
        chk(count, v);
    endtask : wait_val
    initial
    begin
        {rst, async_sel, osc, cnt_wr, cmp_wr, cs, wm, flag_clr, mask} = '0;
        {cnt_wd, cmp_wd} = '0;
        rst = 1'h1;
        cyc(4);
        chk({count, flags, ovf_irq, cmp_irq, cmp_out, top_hit, bot_hit, cmp_val}, 8'h00);
        cyc(4);
        rst <= 1'h0;
        // ****************************************************************
        // clock select rows
        // ****************************************************************
        for (i = 0; i < 8; i++)
        begin
            wr_cnt(8'h00);
            @(posedge clk);
            cs <= row_cs[i];
            repeat (row_n[i]) @(posedge clk);
            cs <= 3'h0;
            cyc(2);
            chk({7'h00, count + row_e[i] >= row_t[i] && count <= row_t[i] + row_e[i]}, 8'h01);
        end
        // ****************************************************************
        // hand-written cases
        // ****************************************************************
        wr_cnt(8'hA5);
        cyc(20);
        chk(count, 8'hA5);
        wr_cmp(8'h10);
        chk(cmp_val, 8'h10);
        wr_cnt(8'hFD);
        set_cs(3'h1);
        wait_val(8'h00);
        chk({6'h00, flags[0], top_hit}, 8'h03);
        chk({7'h00, ovf_irq}, 8'h00);
        mask <= 2'h1;
        cyc(1);
        chk({6'h00, bot_hit, ovf_irq}, 8'h03);
        set_cs(3'h0);
        clr(2'h3);
        chk({6'h00, flags}, 8'h00);
        wr_cmp(8'h08);
        wr_cnt(8'h05);
        co0 = cmp_out;
        set_cs(3'h1);
        wait_val(8'h08);
        chk({7'h00, flags[1]}, 8'h00);
        cyc(1);
        chk({7'h00, flags[1]}, 8'h01);
        mask <= 2'h2;
        cyc(2);
        chk({6'h00, flags[1], cmp_irq}, 8'h03);
        chk({7'h00, cmp_out ^ co0}, 8'h01);
        set_cs(3'h0);
        clr(2'h3);
        wr_cnt(8'h08);
        set_cs(3'h1);
        cyc(4);
        chk({7'h00, flags[1]}, 8'h00);
        wr_cnt(8'h40);
        chk(count, 8'h40);
        set_cs(3'h0);
        wr_cmp(8'h05);
        wr_cnt(8'h00);
        wm <= 2'h2;
        set_cs(3'h1);
        for (i = 0; i < 20; i++)
        begin
            cyc(1);
            chk({7'h00, count <= 8'h05}, 8'h01);
        end
        set_cs(3'h0);
        wm <= 2'h1;
        wr_cnt(8'hFD);
        set_cs(3'h1);
        wait_val(8'hFF);
        cyc(2);
        chk({7'h00, count < 8'hFF && count > 8'hF0}, 8'h01);
        set_cs(3'h0);
        wm <= 2'h0;
        wr_cnt(8'h00);
        async_sel <= 1'h1;
        set_cs(3'h1);
        cyc(20);
        chk(count, 8'h00);
        for (i = 0; i < 20; i++)
        begin
            osc <= ~osc;
            cyc(8);
        end
        chk({7'h00, count >= 8'h09 && count <= 8'h0B}, 8'h01);
        rst <= 1'h1;
        cyc(2);
        chk({count, flags}, 10'h000);
        tally_and_finish();
    end
endmodule : atc_core_tb
